// File: inc/msc_params.svh
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH

// Register offsets
`define MSC_ADDR_DAC_FIRST                8'h10
`define MSC_ADDR_DAC_LAST                 8'h17
`define MSC_ADDR_MONITOR_CONTROL_CFG      8'h18
`define MSC_ADDR_MEASURE_MODE_CFG         8'h19
`define MSC_ADDR_CONVERSION_DAC_CTRL_CFG  8'h1a
`define MSC_ADDR_DAC_OUTPUT_CFG           8'h1b
`define MSC_ADDR_DAC_LOAD_REF_CFG         8'h1c

// Reset values
`define MSC_RST_CFG                       8'h00

// monitor_control_cfg fields
`define MSC_MONITOR_RUN_OR_FAST_CLOCK_BIT 0
`define MSC_ALERT_ENABLE_BIT              1
`define MSC_CHAN_AVG_OFF_LSB              2
`define MSC_ALERT_POLARITY_BIT            6
`define MSC_SOFT_RESET_BIT                7

// measure_mode_cfg fields
`define MSC_SINGLE_CHAN_LSB               0
`define MSC_SINGLE_CHANNEL_SELECT         4
`define MSC_AVERAGING_DISABLE             5
`define MSC_SMBUS_TIMEOUT_BIT             7

// conversion_dac_ctrl_cfg fields
`define MSC_THERMAL_RES10_BIT             1
`define MSC_DAC_UPDATE_SOURCE_SELECT      3
`define MSC_DAC_A_TEMP_BIT                5
`define MSC_DAC_B_TEMP_BIT                6

// dac_output_cfg and dac_load_ref_cfg fields
`define MSC_LOAD_AB_ON_WRITE_BIT          4
`define MSC_LOAD_CD_ON_WRITE_BIT          5
`define MSC_REF_BUF_OFF_LSB               6
`define MSC_INT_REF_BIT                   4

// Timing
`define MSC_CLK_HZ                        100000000
`define MSC_CAL_TIME_US                   5000
`define MSC_CAL_CYCLES                    (`MSC_CAL_TIME_US * (`MSC_CLK_HZ / 1000000))
`define MSC_ADC_SLOW_HZ                   1400
`define MSC_ADC_FAST_HZ                   22000
`define MSC_ADC_SLOW_DIV                  (`MSC_CLK_HZ / `MSC_ADC_SLOW_HZ)
`define MSC_ADC_FAST_DIV                  (`MSC_CLK_HZ / `MSC_ADC_FAST_HZ)

// Averaging and supply correction
`define MSC_AVG_COUNT                     5'd16
`define MSC_AVG_SHIFT                     4
`define MSC_VDD_NOMINAL                   10'h200
`define MSC_VDD_CORR_SHIFT                3

`endif

// File: inc/msc_pkg.sv
package msc_pkg;
	typedef enum logic [1:0] {ST_CAL, ST_IDLE, ST_TICK, ST_SAMPLE} msc_state_t;
	typedef enum logic [1:0] {CH_VDD, CH_INT, CH_EXT} msc_chan_t;
endpackage : msc_pkg

// File: hdl/msc_adc_clk.sv
`timescale 1ns/100ps
`include "msc_params.svh"

module msc_adc_clk #(
	parameter int SLOW_DIV = `MSC_ADC_SLOW_DIV,
	parameter int FAST_DIV = `MSC_ADC_FAST_DIV
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// Control
	input  wire logic fast,
	// Conversion clock tick
	output logic      tick
);
	logic [16:0] cnt;
	logic [16:0] next_cnt;
	logic [16:0] limit;

	always_comb begin
		limit    = fast ? 17'(FAST_DIV - 1) : 17'(SLOW_DIV - 1);
		tick     = (cnt >= limit);
		next_cnt = tick ? 17'h00000 : cnt + 17'h00001;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 17'h00000;
		end else begin
			cnt <= next_cnt;
		end
	end
endmodule : msc_adc_clk

// File: hdl/msc_top.sv
// How it works
// - After calibration idle, no measurement, DACs 0
// - Run bit set starts round-robin monitoring
// - Round robin: supply, internal, external, repeat
// - Clearing run bit stops monitoring
// - Single-channel bit switches to one channel
// - Averaging on by default, 16 readings
// - Averaging disable gives single-reading results
// - DAC codes written at 0x10 to 0x17
// - Default: strobe pin low pulse loads DACs
// - Source select moves loading to registers
// - Config sets range, reference buffer, reference
// - DAC A/B can follow internal/external temperature
// - Serial interface starts in I2C mode
// - SPI locks until power cycle
// - Config gives alert, polarity, averaging, timeout, reset
// - Calibration 5 ms; traffic interrupts it
// - Latest supply reading corrects temperatures
// - ADC clock 1.4 kHz, fast bit 22 kHz
// - Fast clock switches external input filters off
// - DAC read returns active code, not pending
// - Strobe falling edge loads; must rise first
`timescale 1ns/100ps
`include "msc_params.svh"

module msc_top #(
	parameter int DAC_BITS   = 12,
	parameter int CAL_CYCLES = `MSC_CAL_CYCLES,
	parameter int SLOW_DIV   = `MSC_ADC_SLOW_DIV,
	parameter int FAST_DIV   = `MSC_ADC_FAST_DIV
) (
	// Clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     rst_n,
	// Register port from serial front end
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	input  wire logic [7:0]               reg_addr,
	input  wire logic [7:0]               reg_wdata,
	output logic      [7:0]               reg_rdata,
	input  wire logic                     spi_select_seen,
	output logic                          serial_spi_mode,
	// DAC load strobe pin
	input  wire logic                     dac_load_strobe_n,
	// ADC sample port
	output logic                          adc_sample_req,
	output logic      [1:0]               adc_channel,
	output logic                          adc_fast,
	output logic                          ext_filter_en,
	input  wire logic                     adc_sample_valid,
	input  wire logic [9:0]               adc_sample,
	// Results and status
	output logic      [9:0]               vdd_result,
	output logic      [9:0]               int_temp_result,
	output logic      [9:0]               ext_temp_result,
	output logic                          cal_busy,
	output logic                          cal_interrupted,
	output logic                          meas_active,
	// Config outputs
	output logic                          alert_enable,
	output logic                          alert_active_high,
	output logic                          smbus_timeout_en,
	// DAC outputs
	output logic      [3:0][DAC_BITS-1:0] dac_code,
	output logic      [3:0]               dac_gain2,
	output logic      [1:0]               dac_ref_buf_off,
	output logic                          dac_int_ref
);
	// Configuration registers
	logic [7:0] monitor_control_cfg, next_monitor_control_cfg;
	logic [7:0] measure_mode_cfg, next_measure_mode_cfg;
	logic [7:0] conversion_dac_ctrl_cfg, next_conversion_dac_ctrl_cfg;
	logic [7:0] dac_output_cfg, next_dac_output_cfg;
	logic [7:0] dac_load_ref_cfg, next_dac_load_ref_cfg;
	logic       spi_locked, next_spi_locked;
	logic [7:0] next_reg_rdata;

	// DAC state
	logic [3:0][DAC_BITS-1:0] dac_in, next_dac_in;
	logic [3:0][DAC_BITS-1:0] next_dac_code;
	logic                     strobe_s1, strobe_s2, strobe_prev;
	logic                     strobe_fall;
	logic [3:0]               load_mask;

	// Sequencer state
	msc_pkg::msc_state_t state, next_state;
	msc_pkg::msc_chan_t  chan, next_chan;
	logic [31:0]         cal_cnt, next_cal_cnt;
	logic [4:0]          avg_cnt, next_avg_cnt;
	logic [13:0]         acc, next_acc;
	logic [9:0]          next_vdd, next_int, next_ext;
	logic                next_cal_int;
	logic                adc_tick;
	logic                run, avg_on, done_reading;
	logic [9:0]          final_val;
	logic [1:0]          temp_load;
	logic [13:0]         acc_sum;

	function automatic msc_pkg::msc_chan_t chan_of(input logic [1:0] code);
		case (code)
			2'h1:    chan_of = msc_pkg::CH_INT;
			2'h2:    chan_of = msc_pkg::CH_EXT;
			default: chan_of = msc_pkg::CH_VDD;
		endcase
	endfunction : chan_of

	function automatic logic [9:0] vdd_correct(input logic [9:0] raw, input logic [9:0] vdd);
		logic signed [10:0] delta;
		delta       = $signed({1'b0, vdd}) - $signed({1'b0, `MSC_VDD_NOMINAL});
		vdd_correct = raw - 10'(delta >>> `MSC_VDD_CORR_SHIFT);
	endfunction : vdd_correct

	function automatic logic [DAC_BITS-1:0] temp_code(input logic [9:0] t, input logic res10);
		temp_code = res10 ? DAC_BITS'(t) : DAC_BITS'(t[9:2]);
	endfunction : temp_code

	msc_adc_clk #(
		.SLOW_DIV (SLOW_DIV),
		.FAST_DIV (FAST_DIV)
	) u_adc_clk (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.fast    (adc_fast),
		.tick    (adc_tick)
	);

	// Config register writes and reads
	always_comb begin
		next_monitor_control_cfg     = monitor_control_cfg;
		next_measure_mode_cfg        = measure_mode_cfg;
		next_conversion_dac_ctrl_cfg = conversion_dac_ctrl_cfg;
		next_dac_output_cfg          = dac_output_cfg;
		next_dac_load_ref_cfg        = dac_load_ref_cfg & 8'hf0;
		next_reg_rdata               = reg_rdata;
		next_spi_locked              = spi_locked | spi_select_seen;
		if (monitor_control_cfg[`MSC_SOFT_RESET_BIT]) begin
			next_monitor_control_cfg     = `MSC_RST_CFG;
			next_measure_mode_cfg        = `MSC_RST_CFG;
			next_conversion_dac_ctrl_cfg = `MSC_RST_CFG;
			next_dac_output_cfg          = `MSC_RST_CFG;
			next_dac_load_ref_cfg        = `MSC_RST_CFG;
		end else if (reg_wr) begin
			case (reg_addr)
				`MSC_ADDR_MONITOR_CONTROL_CFG:     next_monitor_control_cfg     = reg_wdata;
				`MSC_ADDR_MEASURE_MODE_CFG:        next_measure_mode_cfg        = reg_wdata;
				`MSC_ADDR_CONVERSION_DAC_CTRL_CFG: next_conversion_dac_ctrl_cfg = reg_wdata;
				`MSC_ADDR_DAC_OUTPUT_CFG:          next_dac_output_cfg          = reg_wdata;
				`MSC_ADDR_DAC_LOAD_REF_CFG:        next_dac_load_ref_cfg        = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				`MSC_ADDR_MONITOR_CONTROL_CFG:     next_reg_rdata = monitor_control_cfg;
				`MSC_ADDR_MEASURE_MODE_CFG:        next_reg_rdata = measure_mode_cfg;
				`MSC_ADDR_CONVERSION_DAC_CTRL_CFG: next_reg_rdata = conversion_dac_ctrl_cfg;
				`MSC_ADDR_DAC_OUTPUT_CFG:          next_reg_rdata = dac_output_cfg;
				`MSC_ADDR_DAC_LOAD_REF_CFG:        next_reg_rdata = dac_load_ref_cfg & 8'hf0;
				default: begin
					if (reg_addr >= `MSC_ADDR_DAC_FIRST && reg_addr <= `MSC_ADDR_DAC_LAST) begin
						next_reg_rdata = reg_addr[0] ?
							8'({4'h0, 16'(dac_code[reg_addr[2:1]]) >> 8}) :
							8'(dac_code[reg_addr[2:1]]);
					end else begin
						next_reg_rdata = 8'h00;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			monitor_control_cfg     <= `MSC_RST_CFG;
			measure_mode_cfg        <= `MSC_RST_CFG;
			conversion_dac_ctrl_cfg <= `MSC_RST_CFG;
			dac_output_cfg          <= `MSC_RST_CFG;
			dac_load_ref_cfg        <= `MSC_RST_CFG;
			reg_rdata               <= 8'h00;
			spi_locked              <= 1'b0;
		end else begin
			monitor_control_cfg     <= next_monitor_control_cfg;
			measure_mode_cfg        <= next_measure_mode_cfg;
			conversion_dac_ctrl_cfg <= next_conversion_dac_ctrl_cfg;
			dac_output_cfg          <= next_dac_output_cfg;
			dac_load_ref_cfg        <= next_dac_load_ref_cfg;
			reg_rdata               <= next_reg_rdata;
			spi_locked              <= next_spi_locked;
		end
	end

	// Config decode
	always_comb begin
		serial_spi_mode   = spi_locked;
		alert_enable      = monitor_control_cfg[`MSC_ALERT_ENABLE_BIT];
		alert_active_high = monitor_control_cfg[`MSC_ALERT_POLARITY_BIT];
		smbus_timeout_en  = measure_mode_cfg[`MSC_SMBUS_TIMEOUT_BIT];
		adc_fast          = conversion_dac_ctrl_cfg[`MSC_MONITOR_RUN_OR_FAST_CLOCK_BIT];
		ext_filter_en     = ~adc_fast;
		dac_gain2         = dac_output_cfg[3:0];
		dac_ref_buf_off   = dac_output_cfg[`MSC_REF_BUF_OFF_LSB +: 2];
		dac_int_ref       = dac_load_ref_cfg[`MSC_INT_REF_BIT];
	end

	// DAC input and active registers
	always_comb begin
		next_dac_in = dac_in;
		if (reg_wr && reg_addr >= `MSC_ADDR_DAC_FIRST && reg_addr <= `MSC_ADDR_DAC_LAST) begin
			if (reg_addr[0]) begin
				next_dac_in[reg_addr[2:1]] = DAC_BITS'({reg_wdata[3:0],
					dac_in[reg_addr[2:1]][7:0]});
			end else begin
				next_dac_in[reg_addr[2:1]] = DAC_BITS'({dac_in[reg_addr[2:1]] >> 8,
					reg_wdata});
			end
		end
		strobe_fall = strobe_prev & ~strobe_s2;
		load_mask   = 4'h0;
		if (conversion_dac_ctrl_cfg[`MSC_DAC_UPDATE_SOURCE_SELECT]) begin
			load_mask = dac_load_ref_cfg[3:0];
			if (reg_wr && reg_addr[0] && reg_addr[7:2] == `MSC_ADDR_DAC_FIRST >> 2) begin
				load_mask[1:0] = load_mask[1:0] | {2{dac_output_cfg[`MSC_LOAD_AB_ON_WRITE_BIT]}};
			end
			if (reg_wr && reg_addr[0] && reg_addr[7:2] == (`MSC_ADDR_DAC_FIRST >> 2) + 6'h01) begin
				load_mask[3:2] = load_mask[3:2] | {2{dac_output_cfg[`MSC_LOAD_CD_ON_WRITE_BIT]}};
			end
		end else begin
			load_mask = {4{strobe_fall}};
		end
		next_dac_code = dac_code;
		for (int i = 0; i < 4; i++) begin
			if (load_mask[i]) begin
				next_dac_code[i] = next_dac_in[i];
			end
		end
		if (temp_load[0]) begin
			next_dac_code[0] = temp_code(next_int,
				conversion_dac_ctrl_cfg[`MSC_THERMAL_RES10_BIT]);
		end
		if (temp_load[1]) begin
			next_dac_code[1] = temp_code(next_ext,
				conversion_dac_ctrl_cfg[`MSC_THERMAL_RES10_BIT]);
		end
		// Outputs held at zero through calibration
		if (state == msc_pkg::ST_CAL) begin
			next_dac_code = '0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dac_in      <= '0;
			dac_code    <= '0;
			strobe_s1   <= 1'b1;
			strobe_s2   <= 1'b1;
			strobe_prev <= 1'b1;
		end else begin
			dac_in      <= next_dac_in;
			dac_code    <= next_dac_code;
			strobe_s1   <= dac_load_strobe_n;
			strobe_s2   <= strobe_s1;
			strobe_prev <= strobe_s2;
		end
	end

	// Measurement sequencer
	always_comb begin
		next_state   = state;
		next_chan    = chan;
		next_cal_cnt = cal_cnt;
		next_cal_int = cal_interrupted;
		next_avg_cnt = avg_cnt;
		next_acc     = acc;
		next_vdd     = vdd_result;
		next_int     = int_temp_result;
		next_ext     = ext_temp_result;
		temp_load    = 2'b00;
		adc_sample_req = 1'b0;
		run          = monitor_control_cfg[`MSC_MONITOR_RUN_OR_FAST_CLOCK_BIT];
		avg_on       = ~measure_mode_cfg[`MSC_AVERAGING_DISABLE] &
			~monitor_control_cfg[`MSC_CHAN_AVG_OFF_LSB + 32'(chan)];
		acc_sum      = acc + 14'(adc_sample);
		done_reading = avg_on ? (avg_cnt == `MSC_AVG_COUNT - 5'd1) : 1'b1;
		final_val    = avg_on ? 10'(acc_sum >> `MSC_AVG_SHIFT) : adc_sample;
		case (state)
			msc_pkg::ST_CAL: begin
				next_cal_cnt = cal_cnt + 32'd1;
				if (reg_wr || reg_rd) begin
					next_cal_int = 1'b1;
					next_state   = msc_pkg::ST_IDLE;
				end else if (cal_cnt >= 32'(CAL_CYCLES - 1)) begin
					next_state = msc_pkg::ST_IDLE;
				end
			end
			msc_pkg::ST_IDLE: begin
				if (run) begin
					next_state   = msc_pkg::ST_TICK;
					next_chan    = measure_mode_cfg[`MSC_SINGLE_CHANNEL_SELECT] ?
						chan_of(measure_mode_cfg[`MSC_SINGLE_CHAN_LSB +: 2]) :
						msc_pkg::CH_VDD;
					next_avg_cnt = 5'd0;
					next_acc     = 14'h0000;
				end
			end
			msc_pkg::ST_TICK: begin
				if (!run) begin
					next_state = msc_pkg::ST_IDLE;
				end else if (adc_tick) begin
					adc_sample_req = 1'b1;
					next_state     = msc_pkg::ST_SAMPLE;
				end
			end
			msc_pkg::ST_SAMPLE: begin
				if (adc_sample_valid) begin
					next_state = msc_pkg::ST_TICK;
					if (!done_reading) begin
						next_acc     = acc_sum;
						next_avg_cnt = avg_cnt + 5'd1;
					end else begin
						next_acc     = 14'h0000;
						next_avg_cnt = 5'd0;
						case (chan)
							msc_pkg::CH_VDD: next_vdd = final_val;
							msc_pkg::CH_INT: begin
								next_int     = vdd_correct(final_val, vdd_result);
								temp_load[0] = conversion_dac_ctrl_cfg[`MSC_DAC_A_TEMP_BIT];
							end
							default: begin
								next_ext     = vdd_correct(final_val, vdd_result);
								temp_load[1] = conversion_dac_ctrl_cfg[`MSC_DAC_B_TEMP_BIT];
							end
						endcase
						if (measure_mode_cfg[`MSC_SINGLE_CHANNEL_SELECT]) begin
							next_chan = chan_of(measure_mode_cfg[`MSC_SINGLE_CHAN_LSB +: 2]);
						end else begin
							case (chan)
								msc_pkg::CH_VDD: next_chan = msc_pkg::CH_INT;
								msc_pkg::CH_INT: next_chan = msc_pkg::CH_EXT;
								default:         next_chan = msc_pkg::CH_VDD;
							endcase
						end
					end
				end
			end
			default: next_state = msc_pkg::ST_IDLE;
		endcase
		cal_busy    = (state == msc_pkg::ST_CAL);
		meas_active = (state == msc_pkg::ST_TICK) || (state == msc_pkg::ST_SAMPLE);
		adc_channel = 2'(chan);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state           <= msc_pkg::ST_CAL;
			chan            <= msc_pkg::CH_VDD;
			cal_cnt         <= 32'd0;
			cal_interrupted <= 1'b0;
			avg_cnt         <= 5'd0;
			acc             <= 14'h0000;
			vdd_result      <= `MSC_VDD_NOMINAL;
			int_temp_result <= 10'h000;
			ext_temp_result <= 10'h000;
		end else begin
			state           <= next_state;
			chan            <= next_chan;
			cal_cnt         <= next_cal_cnt;
			cal_interrupted <= next_cal_int;
			avg_cnt         <= next_avg_cnt;
			acc             <= next_acc;
			vdd_result      <= next_vdd;
			int_temp_result <= next_int;
			ext_temp_result <= next_ext;
		end
	end
endmodule : msc_top

// File: verification/msc_top_props.sv
`timescale 1ns/100ps
module msc_top_props #(
	parameter int DAC_BITS = 12
) (
	// Clock and reset
	input wire logic                     ref_clk,
	input wire logic                     rst_n,
	// Register port
	input wire logic                     reg_wr,
	input wire logic                     reg_rd,
	input wire logic [7:0]               reg_addr,
	input wire logic [7:0]               reg_wdata,
	input wire logic [7:0]               reg_rdata,
	input wire logic                     spi_select_seen,
	input wire logic                     serial_spi_mode,
	// ADC and status
	input wire logic                     adc_sample_req,
	input wire logic                     adc_fast,
	input wire logic                     ext_filter_en,
	input wire logic                     cal_busy,
	input wire logic                     meas_active,
	input wire logic [3:0][DAC_BITS-1:0] dac_code
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	cal_outputs_quiet_a: assert property (cal_busy |-> dac_code == '0 && !meas_active)
		else $error("DAC code or monitoring seen during calibration");
	run_start_a: assert property (reg_wr && reg_addr == 8'h18 && reg_wdata[0]
		&& !reg_wdata[7] && !cal_busy && !meas_active |-> ##2 meas_active)
		else $error("monitoring did not start after run bit");
	run_stop_a: assert property (reg_wr && reg_addr == 8'h18 && !reg_wdata[0]
		|-> ##[1:60] !meas_active)
		else $error("monitoring did not stop after run bit cleared");
	i2c_default_a: assert property (!spi_select_seen && !serial_spi_mode |=> !serial_spi_mode)
		else $error("interface left default mode without selection");
	spi_lock_a: assert property (spi_select_seen || serial_spi_mode |=> serial_spi_mode)
		else $error("selected interface mode not held");
	fast_clock_sel_a: assert property (reg_wr && reg_addr == 8'h1a
		|-> ##2 adc_fast == $past(reg_wdata[0], 2))
		else $error("conversion speed does not follow its bit");
	filter_off_fast_a: assert property (ext_filter_en == !adc_fast)
		else $error("input filter state wrong for clock speed");
	req_single_pulse_a: assert property (adc_sample_req |=> !adc_sample_req)
		else $error("sample request longer than one cycle");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");
endmodule : msc_top_props

bind msc_top msc_top_props #(.DAC_BITS(DAC_BITS)) u_msc_top_props (
	.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .spi_select_seen(spi_select_seen),
	.serial_spi_mode(serial_spi_mode), .adc_sample_req(adc_sample_req), .adc_fast(adc_fast),
	.ext_filter_en(ext_filter_en), .cal_busy(cal_busy), .meas_active(meas_active),
	.dac_code(dac_code));

// File: verification/msc_adc_model.sv
`timescale 1ns/100ps
module msc_adc_model #(
	parameter logic [9:0] VB = 10'h240,
	parameter logic [9:0] IB = 10'h150,
	parameter logic [9:0] EB = 10'h0e0
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Latency select
	input  wire logic       slow,
	// Sample port
	input  wire logic       adc_sample_req,
	input  wire logic [1:0] adc_channel,
	output logic            adc_sample_valid,
	output logic      [9:0] adc_sample
);
	logic [2:0] cnt;
	logic [1:0] ch;
	logic [2:0] par;
	function automatic logic [9:0] base(input logic [1:0] c);
		return (c == 2'h0) ? VB : (c == 2'h1) ? IB : EB;
	endfunction : base
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt              <= 3'h0;
			ch               <= 2'h0;
			par              <= 3'h0;
			adc_sample_valid <= 1'b0;
			adc_sample       <= 10'h3ff;
		end else begin
			adc_sample_valid <= 1'b0;
			// Idle bus toggles
			adc_sample       <= ~adc_sample;
			if (adc_sample_req && !slow) begin
				adc_sample_valid <= 1'b1;
				adc_sample       <= base(adc_channel) + {8'h00, par[adc_channel], 1'b0};
				par[adc_channel] <= ~par[adc_channel];
			end else if (adc_sample_req) begin
				cnt <= 3'h4;
				ch  <= adc_channel;
			end else if (cnt == 3'h1) begin
				cnt              <= 3'h0;
				adc_sample_valid <= 1'b1;
				adc_sample       <= base(ch) + {8'h00, par[ch], 1'b0};
				par[ch]          <= ~par[ch];
			end else if (cnt != 3'h0) begin
				cnt <= cnt - 3'h1;
			end
		end
	end
endmodule : msc_adc_model

// File: verification/testbench.sv
`timescale 1ns/100ps
module testbench;
	localparam logic [9:0]  VB = 10'h240, IB = 10'h150, EB = 10'h0e0, CR = 10'h008;
	localparam logic [23:0] ROWS [6] = '{24'h198080, 24'h1bcfcf, 24'h1c1f10, 24'h205a00,
		24'h184242, 24'h103400};
	logic             ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, slow = 0;
	// No select traffic while host talks I2C
	logic             spi_select_seen = 0, dac_load_strobe_n = 1;
	logic [7:0]       reg_addr = 0, reg_wdata = 0, reg_rdata, rd;
	logic             adc_sample_req, adc_fast, ext_filter_en, adc_sample_valid, serial_spi_mode;
	logic [1:0]       adc_channel, ch, dac_ref_buf_off;
	logic [9:0]       adc_sample, vdd_result, int_temp_result, ext_temp_result;
	logic             cal_busy, cal_interrupted, meas_active, dac_int_ref;
	logic             alert_enable, alert_active_high, smbus_timeout_en;
	logic [3:0][11:0] dac_code;
	logic [3:0]       dac_gain2;
	int               n_mismatch = 0, n_compared = 0, cycles = 0, t0 = 0, gap = 0, i;

	always #5 ref_clk = ~ref_clk;

	msc_top #(.DAC_BITS(12), .CAL_CYCLES(20), .SLOW_DIV(8), .FAST_DIV(4)) u_msc_top (
		.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.spi_select_seen(spi_select_seen), .serial_spi_mode(serial_spi_mode),
		.dac_load_strobe_n(dac_load_strobe_n), .adc_sample_req(adc_sample_req),
		.adc_channel(adc_channel), .adc_fast(adc_fast), .ext_filter_en(ext_filter_en),
		.adc_sample_valid(adc_sample_valid), .adc_sample(adc_sample),
		.vdd_result(vdd_result), .int_temp_result(int_temp_result),
		.ext_temp_result(ext_temp_result), .cal_busy(cal_busy),
		.cal_interrupted(cal_interrupted), .meas_active(meas_active),
		.alert_enable(alert_enable), .alert_active_high(alert_active_high),
		.smbus_timeout_en(smbus_timeout_en), .dac_code(dac_code), .dac_gain2(dac_gain2),
		.dac_ref_buf_off(dac_ref_buf_off), .dac_int_ref(dac_int_ref));

	msc_adc_model #(.VB(VB), .IB(IB), .EB(EB)) u_msc_adc_model (
		.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .adc_sample_req(adc_sample_req),
		.adc_channel(adc_channel), .adc_sample_valid(adc_sample_valid),
		.adc_sample(adc_sample));

	task report_and_stop;
		$display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask : wr

	task rdr(input logic [7:0] a);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1 rd = reg_rdata;
	endtask : rdr

	task strobe(input logic v);
		@(posedge ref_clk);
		dac_load_strobe_n <= v;
		repeat (6) @(negedge ref_clk);
	endtask : strobe

	task wait_req;
		int k;
		for (k = 0; k < 400; k++) begin
			@(negedge ref_clk);
			if (adc_sample_req === 1'b1) break;
		end
		ch  = adc_channel;
		gap = cycles - t0;
		t0  = cycles;
	endtask : wait_req

	task wait_stop;
		int k;
		for (k = 0; k < 100 && meas_active !== 1'b0; k++) @(negedge ref_clk);
		chk("meas_active", meas_active, 16'h0000);
	endtask : wait_stop

	initial begin
		@(negedge ref_clk);
		chk("cal_busy", cal_busy, 16'h0001);
		chk("dac_code", 16'(|dac_code), 16'h0000);
		chk("vdd_result", vdd_result, 16'h0200);
		chk("spi_mode", serial_spi_mode, 16'h0000);
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (i = 0; i < 100 && cal_busy !== 1'b0; i++) @(negedge ref_clk);
		chk("cal_interrupted", cal_interrupted, 16'h0000);
		for (i = 0; i < 5; i++) begin
			rdr(8'h18 + 8'(i));
			chk("cfg_reset", rd, 16'h0000);
		end
		foreach (ROWS[i]) begin
			wr(ROWS[i][23:16], ROWS[i][15:8]);
			rdr(ROWS[i][23:16]);
			chk("reg_row", rd, 16'(ROWS[i][7:0]));
		end
		chk("alerts", {alert_enable, alert_active_high, smbus_timeout_en}, 16'h0007);
		chk("dac_cfg", {dac_gain2, dac_ref_buf_off, dac_int_ref}, 16'h007f);
		wr(8'h11, 8'h0a);
		strobe(1'b0);
		chk("dac_a", dac_code[0], 16'h0a34);
		rdr(8'h10);
		chk("dac_a_read", rd, 16'h0034);
		wr(8'h10, 8'h55);
		repeat (6) @(negedge ref_clk);
		chk("dac_a_held", dac_code[0], 16'h0a34);
		strobe(1'b1);
		strobe(1'b0);
		chk("dac_a_reload", dac_code[0], 16'h0a55);
		strobe(1'b1);
		wr(8'h1a, 8'h08);
		wr(8'h12, 8'h77);
		wr(8'h13, 8'h01);
		strobe(1'b0);
		strobe(1'b1);
		chk("dac_b_pin", dac_code[1], 16'h0000);
		wr(8'h1c, 8'h02);
		repeat (3) @(negedge ref_clk);
		chk("dac_b_mask", dac_code[1], 16'h0177);
		wr(8'h1b, 8'h10);
		wr(8'h12, 8'h11);
		wr(8'h13, 8'h02);
		@(negedge ref_clk);
		chk("dac_b_write", dac_code[1], 16'h0211);
		wr(8'h18, 8'h01);
		for (i = 0; i < 48; i++) begin
			wait_req();
			chk("rr_channel", ch, 16'((i / 16) % 3));
		end
		repeat (3) @(negedge ref_clk);
		chk("vdd_avg", vdd_result, 16'(VB + 10'h001));
		chk("int_corr", int_temp_result, 16'(IB + 10'h001 - CR));
		chk("ext_corr", ext_temp_result, 16'(EB + 10'h001 - CR));
		wr(8'h18, 8'h00);
		wait_stop();
		wr(8'h19, 8'h20);
		wr(8'h18, 8'h01);
		for (i = 0; i < 6; i++) begin
			wait_req();
			chk("noavg_channel", ch, 16'(i % 3));
		end
		chk("slow_gap", gap, 16'h0008);
		wr(8'h19, 8'h32);
		wait_req();
		wait_req();
		for (i = 0; i < 3; i++) begin
			wait_req();
			chk("single_channel", ch, 16'h0002);
		end
		chk("still_active", meas_active, 16'h0001);
		wr(8'h1a, 8'h01);
		@(negedge ref_clk);
		chk("fast_filter", {adc_fast, ext_filter_en}, 16'h0002);
		wait_req();
		wait_req();
		chk("fast_gap", gap, 16'h0004);
		slow <= 1'b1;
		for (i = 0; i < 3; i++) wait_req();
		slow <= 1'b0;
		wr(8'h19, 8'h11);
		wr(8'h1a, 8'h22);
		for (i = 0; i < 34; i++) wait_req();
		repeat (3) @(negedge ref_clk);
		chk("dac_a_temp", dac_code[0], 16'(IB + 10'h001 - CR));
		@(posedge ref_clk);
		spi_select_seen <= 1'b1;
		@(posedge ref_clk);
		spi_select_seen <= 1'b0;
		wr(8'h18, 8'h80);
		repeat (2) @(negedge ref_clk);
		rdr(8'h19);
		chk("soft_reset", rd, 16'h0000);
		chk("spi_locked", serial_spi_mode, 16'h0001);
		wait_stop();
		@(posedge ref_clk);
		rst_n <= 1'b0;
		@(posedge ref_clk);
		rst_n <= 1'b1;
		@(negedge ref_clk);
		chk("spi_cleared", serial_spi_mode, 16'h0000);
		rdr(8'h18);
		repeat (2) @(negedge ref_clk);
		chk("cal_hit", {cal_interrupted, cal_busy}, 16'h0002);
		report_and_stop();
	end
endmodule : testbench
